/* File: inc/protect_ctl_pkg.sv */
package protect_ctl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // flash bus geometry
  localparam int FLASH_AW = 23;
  localparam int PW_BYTES = 8;
  localparam int UNLOCK_CYCLES = 11;

  ////////////////////////////////////////////////////////////////////////////
  // apb register map of the controller
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_DATA   = 8'h08;
  localparam logic [7:0] OFS_PW_LO  = 8'h0c;
  localparam logic [7:0] OFS_PW_HI  = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_RDATA  = 8'h18;

  // ctrl fields
  localparam int CTRL_OP_LSB  = 0;
  localparam int CTRL_SEL_LSB = 4;
  // status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ERR_BIT  = 1;
  localparam int STAT_ACT_BIT  = 3;
  localparam int STAT_SET_LSB  = 4;
  localparam int STAT_PROT_BIT = 8;

  ////////////////////////////////////////////////////////////////////////////
  // operations software may start
  localparam logic [3:0] OP_ENTER      = 4'h0;
  localparam logic [3:0] OP_EXIT       = 4'h1;
  localparam logic [3:0] OP_RESET      = 4'h2;
  localparam logic [3:0] OP_PROGRAM    = 4'h3;
  localparam logic [3:0] OP_PROT_SET   = 4'h4;
  localparam logic [3:0] OP_DYN_CLR    = 4'h5;
  localparam logic [3:0] OP_ERASE      = 4'h6;
  localparam logic [3:0] OP_STATUS     = 4'h7;
  localparam logic [3:0] OP_PW_READ    = 4'h8;
  localparam logic [3:0] OP_UNLOCK     = 4'h9;
  localparam logic [3:0] OP_ARRAY_READ = 4'ha;

  // command set selection
  localparam logic [2:0] SEL_LOCK     = 3'h0;
  localparam logic [2:0] SEL_PASSWORD = 3'h1;
  localparam logic [2:0] SEL_PERSIST  = 3'h2;
  localparam logic [2:0] SEL_FREEZE   = 3'h3;
  localparam logic [2:0] SEL_DYNAMIC  = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // bus cycle codes
  localparam logic [11:0] ADDR_AAA = 12'haaa;
  localparam logic [11:0] ADDR_555 = 12'h555;
  localparam logic [7:0]  UNLOCK1_DATA   = 8'haa;
  localparam logic [7:0]  UNLOCK2_DATA   = 8'h55;
  localparam logic [7:0]  CODE_LOCK      = 8'h40;
  localparam logic [7:0]  CODE_PASSWORD  = 8'h60;
  localparam logic [7:0]  CODE_PERSIST   = 8'hc0;
  localparam logic [7:0]  CODE_FREEZE    = 8'h50;
  localparam logic [7:0]  CODE_DYNAMIC   = 8'he0;
  localparam logic [7:0]  EXIT1_DATA     = 8'h90;
  localparam logic [7:0]  EXIT2_DATA     = 8'h00;
  localparam logic [7:0]  RESET_DATA     = 8'hf0;
  localparam logic [7:0]  PROGRAM_DATA   = 8'ha0;
  localparam logic [7:0]  PROT_SET_DATA  = 8'h00;
  localparam logic [7:0]  DYN_CLR_DATA   = 8'h01;
  localparam logic [7:0]  ERASE1_DATA    = 8'h80;
  localparam logic [7:0]  ERASE2_DATA    = 8'h30;
  localparam logic [7:0]  PW_UNLOCK1     = 8'h25;
  localparam logic [7:0]  PW_UNLOCK2     = 8'h03;
  localparam logic [7:0]  PW_UNLOCK_END  = 8'h29;

  ////////////////////////////////////////////////////////////////////////////
  // timing, least times rounded up to whole ref_clk cycles
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_SETUP_NS    = 25;
  localparam int T_WP_NS       = 35;
  localparam int T_RECOVER_NS  = 20;
  localparam int T_ACC_NS      = 70;
  localparam int SETUP_CYC   = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC      = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_CYC     = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic [FLASH_AW-1:0] addr;
    logic [7:0]          dq_out;
    logic                dq_oe;
    logic                ce_n;
    logic                we_n;
    logic                oe_n;
  } flash_pins_s;

  typedef struct packed {
    logic                wr;
    logic [FLASH_AW-1:0] addr;
    logic [7:0]          data;
  } cycle_s;

endpackage : protect_ctl_pkg

/* File: hw/flash_cycle_engine.sv */
`timescale 1ns/10ps
module flash_cycle_engine
  import protect_ctl_pkg::*;
#(
  parameter int CNT_W = 4
)(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // cycle request
  input  wire logic        start,
  input  wire cycle_s      cyc,
  output logic             done,
  output logic [7:0]       rdata,
  // flash pins
  output flash_pins_s      pins,
  input  wire logic [7:0]  dq_in
);

  generate
    if (CNT_W < 1 || ACC_CYC > (1 << CNT_W) || WP_CYC > (1 << CNT_W) ||
        SETUP_CYC > (1 << CNT_W) || RECOVER_CYC > (1 << CNT_W))
    begin : g_bad_cnt
      $error("counter too narrow for cycle timing");
    end
  endgenerate

  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_RECOVER} eng_e;

  typedef struct packed {
    eng_e             st;
    logic [CNT_W-1:0] cnt;
    logic             wr;
    flash_pins_s      pins;
    logic [7:0]       rdata;
    logic             done;
  } eng_s;

  localparam eng_s ENG_RESET = '{st: E_IDLE, cnt: '0, wr: 1'b0,
    pins: '{addr: '0, dq_out: 8'h00, dq_oe: 1'b0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1},
    rdata: 8'h00, done: 1'b0};

  eng_s s_r;
  eng_s s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    case (s_r.st)
      E_IDLE:
      begin
        if (start)
        begin
          s_nxt.wr          = cyc.wr;
          s_nxt.pins.addr   = cyc.addr;
          s_nxt.pins.dq_out = cyc.data;
          s_nxt.pins.dq_oe  = cyc.wr;
          s_nxt.pins.ce_n   = 1'b0;
          s_nxt.cnt         = CNT_W'(SETUP_CYC - 1);
          s_nxt.st          = E_SETUP;
        end
      end
      E_SETUP:
      begin
        if (s_r.cnt == '0)
        begin
          // address has settled, now the strobe
          s_nxt.pins.we_n = ~s_r.wr;
          s_nxt.pins.oe_n = s_r.wr;
          s_nxt.cnt       = s_r.wr ? CNT_W'(WP_CYC - 1) : CNT_W'(ACC_CYC - 1);
          s_nxt.st        = E_STROBE;
        end
        else
          s_nxt.cnt = s_r.cnt - 1'b1;
      end
      E_STROBE:
      begin
        if (s_r.cnt == '0)
        begin
          s_nxt.pins.we_n = 1'b1;
          s_nxt.pins.oe_n = 1'b1;
          // data is sampled at the end of the access time, before oe rises
          if (!s_r.wr)
            s_nxt.rdata = dq_in;
          s_nxt.cnt = CNT_W'(RECOVER_CYC - 1);
          s_nxt.st  = E_RECOVER;
        end
        else
          s_nxt.cnt = s_r.cnt - 1'b1;
      end
      E_RECOVER:
      begin
        if (s_r.cnt == '0)
        begin
          s_nxt.pins.ce_n  = 1'b1;
          s_nxt.pins.dq_oe = 1'b0;
          s_nxt.done       = 1'b1;
          s_nxt.st         = E_IDLE;
        end
        else
          s_nxt.cnt = s_r.cnt - 1'b1;
      end
      default:
        s_nxt = ENG_RESET;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      s_r <= ENG_RESET;
    else
      s_r <= s_nxt;
  end

  assign pins  = s_r.pins;
  assign done  = s_r.done;
  assign rdata = s_r.rdata;

endmodule : flash_cycle_engine

/* File: hw/protect_cmd_host.sv */
// Function
// (R1) enter a command set with AA@AAA, 55@555, then the set code @AAA
// (R2) set codes: 40 lock, 60 password, C0 persistent, 50 freeze, E0 dynamic
// (R3) leave a command set with 90 then 00 at any address
// (R4) a single F0 write also leaves the set; always exit before other work
// (R5) each password byte is programmed with A0 then the byte value
// (R6) password bytes sit at addresses 00 to 07 of sector zero
// (R7) password read is eight reads at 00 to 07, full address driven
// (R8) unlock: 25, 03 at 00, eight password bytes, then 29 at 00
// (R9) persistent protect bit set: A0 then 00 inside the sector
// (R10) erase all persistent bits: 80 then 30 at 00
// (R11) protection status read gives data bit zero low when protected
// (R12) freeze bit set with A0 then 00; one read returns it on bit zero
// (R13) dynamic bit: A0,00 sets, A0,01 clears; accelerate input high when setting
// (R14) any address inside a sector names it; undefined bits are ignored
// (R15) host never issues wrong or out-of-order cycles; F0 recovers the device
// (R16) plain array reads need no command cycles
// (R17) sector is chosen by upper address bits down to 15 or 12
// (R18) commands outside the active set are ignored; set stays until exit
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module protect_cmd_host
  import protect_ctl_pkg::*;
#(
  parameter int ADDR_W = FLASH_AW
)(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // flash pins
  output flash_pins_s      flash,
  input  wire logic [7:0]  dq_in,
  output logic             accelerate_input
);

  generate
    if (ADDR_W != FLASH_AW)
    begin : g_bad_aw
      $error("address width must match the flash pin carrier");
    end
  endgenerate

  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} seq_e;

  typedef struct packed {
    seq_e              st;
    logic [3:0]        op;
    logic [2:0]        sel;
    logic [3:0]        idx;
    logic              set_act;
    logic [2:0]        set_cur;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
    logic [63:0]       pw;
    logic [7:0]        rdata;
    logic              err;
    logic              acc;
  } host_s;

  localparam host_s HOST_RESET = '{st: S_IDLE, op: OP_RESET, sel: SEL_LOCK, idx: 4'h0,
    set_act: 1'b0, set_cur: SEL_LOCK, addr: '0, data: 8'h00, pw: 64'h0,
    rdata: 8'h00, err: 1'b0, acc: 1'b0};

  host_s       s_r;
  host_s       s_nxt;
  cycle_s      cyc;
  logic        last;
  logic        eng_done;
  logic [7:0]  eng_rdata;
  logic        wr_en;
  logic        rd_en;
  logic        legal;
  logic [3:0]  new_op;
  logic [2:0]  new_sel;
  logic [7:0]  set_code;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode: no wait states
  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign new_op  = pwdata[CTRL_OP_LSB +: 4];
  assign new_sel = pwdata[CTRL_SEL_LSB +: 3];

  always_comb
  begin
    pslverr = 1'b0;
    prdata  = 32'h0000_0000;
    case (paddr)
      OFS_CTRL:   prdata = {25'h0, s_r.sel, s_r.op};
      OFS_ADDR:   prdata = {{(32 - ADDR_W){1'b0}}, s_r.addr};
      OFS_DATA:   prdata = {24'h0, s_r.data};
      OFS_PW_LO:  prdata = s_r.pw[31:0];
      OFS_PW_HI:  prdata = s_r.pw[63:32];
      OFS_STATUS:
      begin
        prdata[STAT_BUSY_BIT]           = (s_r.st != S_IDLE);
        prdata[STAT_ERR_BIT]            = s_r.err;
        prdata[STAT_ACT_BIT]            = s_r.set_act;
        prdata[STAT_SET_LSB +: 3]       = s_r.set_cur;
        prdata[STAT_PROT_BIT]           = ~s_r.rdata[0]; // [R11]
      end
      OFS_RDATA:  prdata = {24'h0, s_r.rdata};
      default:    pslverr = psel & penable;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // which operations the open set accepts
  always_comb
  begin
    legal = 1'b0;
    case (new_op)
      OP_ENTER:      legal = ~s_r.set_act && (new_sel <= SEL_DYNAMIC);
      OP_EXIT:       legal = s_r.set_act;
      OP_RESET:      legal = 1'b1; // [R15]
      OP_PROGRAM:    legal = s_r.set_act &&
                             (s_r.set_cur == SEL_LOCK || s_r.set_cur == SEL_PASSWORD);
      OP_PROT_SET:   legal = s_r.set_act && (s_r.set_cur == SEL_PERSIST ||
                             s_r.set_cur == SEL_FREEZE || s_r.set_cur == SEL_DYNAMIC);
      OP_DYN_CLR:    legal = s_r.set_act && (s_r.set_cur == SEL_DYNAMIC);
      OP_ERASE:      legal = s_r.set_act && (s_r.set_cur == SEL_PERSIST);
      OP_STATUS:     legal = s_r.set_act && (s_r.set_cur != SEL_PASSWORD);
      OP_PW_READ,
      OP_UNLOCK:     legal = s_r.set_act && (s_r.set_cur == SEL_PASSWORD);
      OP_ARRAY_READ: legal = ~s_r.set_act; // [R16]
      default:       legal = 1'b0;
    endcase
  end

  always_comb
  begin
    case (s_r.sel)
      SEL_LOCK:     set_code = CODE_LOCK; // [R2]
      SEL_PASSWORD: set_code = CODE_PASSWORD;
      SEL_PERSIST:  set_code = CODE_PERSIST;
      SEL_FREEZE:   set_code = CODE_FREEZE;
      default:      set_code = CODE_DYNAMIC;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus cycle for the current step of the running operation
  always_comb
  begin
    cyc  = '0;
    last = 1'b0;
    case (s_r.op)
      OP_ENTER:
      begin
        cyc.wr = 1'b1;
        case (s_r.idx)
          4'h0:
          begin
            cyc.addr = ADDR_W'(ADDR_AAA); // [R1]
            cyc.data = UNLOCK1_DATA;
          end
          4'h1:
          begin
            cyc.addr = ADDR_W'(ADDR_555);
            cyc.data = UNLOCK2_DATA;
          end
          default:
          begin
            cyc.addr = ADDR_W'(ADDR_AAA);
            cyc.data = set_code;
          end
        endcase
        last = (s_r.idx == 4'h2);
      end
      OP_EXIT:
      begin
        cyc.wr   = 1'b1;
        cyc.data = (s_r.idx == 4'h0) ? EXIT1_DATA : EXIT2_DATA; // [R3]
        last     = (s_r.idx == 4'h1);
      end
      OP_RESET:
      begin
        cyc.wr   = 1'b1;
        cyc.data = RESET_DATA; // [R4]
        last     = 1'b1;
      end
      OP_PROGRAM, OP_PROT_SET, OP_DYN_CLR:
      begin
        cyc.wr = 1'b1;
        if (s_r.idx == 4'h0)
          cyc.data = PROGRAM_DATA; // [R5] [R9] [R12] [R13]
        else
        begin
          cyc.addr = s_r.addr; // [R14] [R17]
          if (s_r.op == OP_PROT_SET)
            cyc.data = PROT_SET_DATA;
          else if (s_r.op == OP_DYN_CLR)
            cyc.data = DYN_CLR_DATA;
          else
            cyc.data = s_r.data;
          // password bytes live in sector zero
          if (s_r.set_cur == SEL_PASSWORD)
            cyc.addr = ADDR_W'(s_r.addr[2:0]); // [R6]
        end
        last = (s_r.idx == 4'h1);
      end
      OP_ERASE:
      begin
        cyc.wr   = 1'b1;
        cyc.data = (s_r.idx == 4'h0) ? ERASE1_DATA : ERASE2_DATA; // [R10]
        last     = (s_r.idx == 4'h1);
      end
      OP_PW_READ:
      begin
        cyc.addr = ADDR_W'(s_r.idx[2:0]); // [R7]
        last     = (s_r.idx == 4'(PW_BYTES - 1));
      end
      OP_UNLOCK:
      begin
        cyc.wr = 1'b1;
        if (s_r.idx == 4'h0)
          cyc.data = PW_UNLOCK1; // [R8]
        else if (s_r.idx == 4'h1)
          cyc.data = PW_UNLOCK2;
        else if (s_r.idx == 4'(UNLOCK_CYCLES - 1))
          cyc.data = PW_UNLOCK_END;
        else
        begin
          cyc.addr = ADDR_W'(s_r.idx - 4'h2);
          cyc.data = s_r.pw[{s_r.idx[2:0] - 3'h2, 3'b000} +: 8];
        end
        last = (s_r.idx == 4'(UNLOCK_CYCLES - 1));
      end
      default:
      begin
        // status and array reads: one read at the given address
        cyc.addr = s_r.addr; // [R11] [R12]
        last     = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and register file
  always_comb
  begin
    s_nxt = s_r;
    if (wr_en)
    begin
      case (paddr)
        OFS_ADDR:   s_nxt.addr = pwdata[ADDR_W-1:0];
        OFS_DATA:   s_nxt.data = pwdata[7:0];
        OFS_PW_LO:  if (s_r.st == S_IDLE) s_nxt.pw[31:0] = pwdata;
        OFS_PW_HI:  if (s_r.st == S_IDLE) s_nxt.pw[63:32] = pwdata;
        OFS_STATUS: if (pwdata[STAT_ERR_BIT]) s_nxt.err = 1'b0;
        default:
        begin
        end
      endcase
    end
    case (s_r.st)
      S_IDLE:
      begin
        if (wr_en && paddr == OFS_CTRL)
        begin
          // a refused order never reaches the pins
          if (!legal)
            s_nxt.err = 1'b1; // [R18]
          else
          begin
            s_nxt.op  = new_op;
            s_nxt.sel = new_sel;
            s_nxt.idx = 4'h0;
            s_nxt.acc = (new_op == OP_PROT_SET) && (s_r.set_cur != SEL_FREEZE); // [R13]
            s_nxt.st  = S_ISSUE;
          end
        end
      end
      S_ISSUE:
        s_nxt.st = S_WAIT;
      S_WAIT:
      begin
        if (eng_done)
        begin
          if (!cyc.wr)
          begin
            if (s_r.op == OP_PW_READ)
              s_nxt.pw[{s_r.idx[2:0], 3'b000} +: 8] = eng_rdata; // [R7]
            else
              s_nxt.rdata = eng_rdata;
          end
          if (last)
          begin
            s_nxt.st  = S_IDLE;
            s_nxt.acc = 1'b0;
            if (s_r.op == OP_ENTER)
            begin
              s_nxt.set_act = 1'b1; // [R1]
              s_nxt.set_cur = s_r.sel;
            end
            else if (s_r.op == OP_EXIT || s_r.op == OP_RESET)
              s_nxt.set_act = 1'b0; // [R3] [R4]
          end
          else
          begin
            s_nxt.idx = s_r.idx + 4'h1;
            s_nxt.st  = S_ISSUE;
          end
        end
      end
      default:
        s_nxt = HOST_RESET;
    endcase
    // software writes to ctrl while busy are refused too
    if (wr_en && paddr == OFS_CTRL && s_r.st != S_IDLE)
      s_nxt.err = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      s_r <= HOST_RESET;
    else
      s_r <= s_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  flash_cycle_engine #(
    .CNT_W (4)
  ) u_engine (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .start   (s_r.st == S_ISSUE),
    .cyc     (cyc),
    .done    (eng_done),
    .rdata   (eng_rdata),
    .pins    (flash),
    .dq_in   (dq_in)
  );

  assign accelerate_input = s_r.acc;

  // read enable kept for symmetry of decode; reads have no side effects
  logic unused_rd;
  assign unused_rd = rd_en;

endmodule : protect_cmd_host

/* File: verification/protect_cmd_host_checker.sv */
`timescale 1ns/10ps
module protect_cmd_host_checker
  import protect_ctl_pkg::*;
(
  // apb side
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  // flash side
  input wire flash_pins_s flash
);
  logic mapped;

  // word-aligned offsets up to the last register
  assign mapped = paddr <= OFS_RDATA && paddr[1:0] == 2'b00;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  //////////////////////////////////////////////////////////////////
  sequence wr_strobe;
    !flash.we_n [*2] ##1 flash.we_n;
  endsequence
  sequence rd_strobe;
    !flash.oe_n [*3] ##1 flash.oe_n;
  endsequence

  AST_PREADY: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  AST_SLVERR: assert property (psel && penable |-> pslverr == !mapped)
    else $error("error response disagrees with address map");
  AST_WE_PULSE: assert property ($fell(flash.we_n) |-> wr_strobe)
    else $error("write strobe width wrong");
  AST_OE_PULSE: assert property ($fell(flash.oe_n) |-> rd_strobe)
    else $error("read strobe width wrong");
  AST_SETUP: assert property ($fell(flash.ce_n) |=> $fell(flash.we_n) || $fell(flash.oe_n))
    else $error("strobe does not follow select by one cycle");
  AST_RECOVER: assert property ($rose(flash.we_n) |-> !flash.ce_n ##1 flash.ce_n && !flash.dq_oe)
    else $error("write recovery wrong");
  AST_CE_GAP: assert property ($rose(flash.ce_n) |-> flash.ce_n [*2])
    else $error("select gap shorter than two cycles");
  AST_HOLD: assert property (!flash.we_n |-> $stable(flash.addr) && $stable(flash.dq_out) && flash.dq_oe)
    else $error("address or data moved during write strobe");
  AST_RD_FREE: assert property (!flash.oe_n |-> !flash.dq_oe && flash.we_n)
    else $error("data bus driven during read");
endmodule : protect_cmd_host_checker

/* File: verification/flash_protect_model.sv */
`timescale 1ns/10ps
module flash_protect_model
  import protect_ctl_pkg::*;
(
  // host pins
  input  wire flash_pins_s flash,
  input  wire logic        accelerate_input,
  output logic [7:0]       dq_in
);
  logic [2:0]   set_r = 3'h7;
  logic [1:0]   entry_r = 2'h0;
  logic [7:0]   prev_r = 8'h0;
  logic [3:0]   ucnt_r = 4'h0;
  logic         uok_r = 1'b0, unlocked_r = 1'b0, freeze_r = 1'b0;
  logic [7:0]   pw_r [PW_BYTES];
  logic [127:0] persist_r = '0, dyn_r = '0;
  logic [7:0]   last_r = 8'h0, rd, d;
  logic [11:0]  lo;
  logic [6:0]   sec;

  assign sec = flash.addr[FLASH_AW-1:16];

  //////////////////////////////////////////////////////////////////
  always @(posedge flash.we_n)
  begin
    d = flash.dq_out;
    lo = flash.addr[11:0];
    if (flash.ce_n !== 1'b0)
      d = d;
    else if (d == RESET_DATA)
      set_r = 3'h7;
    else if (set_r == 3'h7)
    begin
      if (entry_r == 2'h2 && lo == ADDR_AAA)
        set_r = d == CODE_LOCK ? 3'h0 : d == CODE_PASSWORD ? 3'h1 : d == CODE_PERSIST ? 3'h2 :
                d == CODE_FREEZE ? 3'h3 : d == CODE_DYNAMIC ? 3'h4 : 3'h7;
      entry_r = (d == UNLOCK1_DATA && lo == ADDR_AAA) ? 2'h1 :
                (entry_r == 2'h1 && d == UNLOCK2_DATA && lo == ADDR_555) ? 2'h2 : 2'h0;
    end
    else if (prev_r == EXIT1_DATA && d == EXIT2_DATA)
      set_r = 3'h7;
    else if (set_r == 3'h1 && (ucnt_r != 0 || (d == PW_UNLOCK1 && prev_r != PROGRAM_DATA)))
    begin
      // every byte must match; one slip spoils the attempt
      uok_r = ucnt_r == 0 ? 1'b1 : ucnt_r == 1 ? uok_r && d == PW_UNLOCK2 : ucnt_r == 10 ?
              uok_r : uok_r && d == pw_r[ucnt_r-2] && lo[2:0] == 3'(ucnt_r - 2);
      unlocked_r = ucnt_r == 10 && uok_r && d == PW_UNLOCK_END;
      ucnt_r = ucnt_r == 10 ? 4'h0 : ucnt_r + 4'h1;
    end
    else if (prev_r == PROGRAM_DATA)
    begin
      if (set_r == 3'h1)
        pw_r[flash.addr[2:0]] = d;
      if (set_r == 3'h2 && d == PROT_SET_DATA && accelerate_input)
        persist_r[sec] = 1'b1;
      if (set_r == 3'h3 && d == PROT_SET_DATA)
        freeze_r = 1'b1;
      if (set_r == 3'h4 && d == PROT_SET_DATA && accelerate_input)
        dyn_r[sec] = 1'b1;
      if (set_r == 3'h4 && d == DYN_CLR_DATA)
        dyn_r[sec] = 1'b0;
    end
    else if (set_r == 3'h2 && prev_r == ERASE1_DATA && d == ERASE2_DATA)
      persist_r = '0; // pre-program then erase seen as all clear
    // a finished pair must not look like a command prefix
    prev_r = (prev_r == PROGRAM_DATA) ? 8'h00 : d;
  end

  //////////////////////////////////////////////////////////////////
  always_comb
  begin
    case (set_r)
      3'h1: rd = flash.addr[FLASH_AW-1:3] == 0 ? pw_r[flash.addr[2:0]] : 8'h3c;
      3'h2: rd = {flash.addr[7:1], ~persist_r[sec]};
      3'h3: rd = {flash.addr[7:1], ~freeze_r};
      3'h4: rd = {flash.addr[7:1], ~dyn_r[sec]};
      default: rd = flash.addr[7:0] ^ 8'h5a;
    endcase
  end

  // no pull on the data bus: released lines show the inverse
  always @(posedge flash.oe_n)
    last_r = rd;
  assign dq_in = (!flash.ce_n && !flash.oe_n) ? rd : ~last_r;
endmodule : flash_protect_model

/* File: verification/protect_cmd_host_bench.sv */
`timescale 1ns/10ps
module protect_cmd_host_bench;
  import protect_ctl_pkg::*;
  localparam logic [63:0] PW_VAL = 64'h0123_4567_89ab_cdef;
  logic        ref_clk, rstn, psel, penable, pwrite, pready, pslverr, err_seen, acc;
  logic [7:0]  paddr, dq_in;
  logic [31:0] pwdata, prdata, rv;
  flash_pins_s flash;
  int          n_mismatch = 0;
  int          total_checks = 0;

  protect_cmd_host i_dut (
    .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash(flash), .dq_in(dq_in), .accelerate_input(acc)
  );
  flash_protect_model i_dev (.flash(flash), .accelerate_input(acc), .dq_in(dq_in));

  //////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rv       = prdata;
    err_seen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // ends with STATUS in rv
  task op(input logic [3:0] o, input logic [2:0] s);
    apb(1'b1, OFS_CTRL, {25'h0, s, o});
    do apb(1'b0, OFS_STATUS, 32'h0); while (rv[STAT_BUSY_BIT] !== 1'b0);
  endtask : op

  task prot(input logic [22:0] a, input logic exp);
    apb(1'b1, OFS_ADDR, {9'h0, a});
    op(OP_STATUS, 3'h0);
    chk({31'h0, rv[STAT_PROT_BIT]}, {31'h0, exp});
  endtask : prot

  //////////////////////////////////////////////////////////////////
  task t_idle;
    apb(1'b0, OFS_STATUS, 32'h0);
    // no read yet: rdata byte 00 reads as protected
    chk(rv, 32'h1 << STAT_PROT_BIT);
    apb(1'b0, 8'h3c, 32'h0);
    chk({31'h0, err_seen}, 32'h1);
    apb(1'b1, OFS_ADDR, 32'h0012_3456);
    op(OP_ARRAY_READ, 3'h0);
    apb(1'b0, OFS_RDATA, 32'h0);
    chk(rv, {24'h0, 8'h56 ^ 8'h5a});
    op(OP_PROGRAM, 3'h0);
    chk({31'h0, rv[STAT_ERR_BIT]}, 32'h1);
    apb(1'b1, OFS_STATUS, 32'h2);
  endtask : t_idle

  task t_sets;
    for (int i = 0; i < 5; i++)
    begin
      op(OP_ENTER, i[2:0]);
      chk({29'h0, i_dev.set_r}, i);
      chk({28'h0, rv[6:3]}, {i[2:0], 1'b1});
      op(OP_ENTER, 3'h4);
      chk({30'h0, rv[STAT_ERR_BIT], i_dev.set_r == i[2:0]}, 32'h3);
      apb(1'b1, OFS_STATUS, 32'h2);
      op(i[0] ? OP_EXIT : OP_RESET, 3'h0);
      chk({29'h0, i_dev.set_r}, 32'h7);
    end
  endtask : t_sets

  task t_password;
    op(OP_ENTER, SEL_PASSWORD);
    for (int i = 0; i < PW_BYTES; i++)
    begin
      apb(1'b1, OFS_ADDR, i);
      apb(1'b1, OFS_DATA, {24'h0, PW_VAL[8*i+:8]});
      op(OP_PROGRAM, 3'h0);
      chk({24'h0, i_dev.pw_r[i]}, {24'h0, PW_VAL[8*i+:8]});
    end
    apb(1'b1, OFS_PW_LO, 32'h0);
    apb(1'b1, OFS_PW_HI, 32'h0);
    op(OP_PW_READ, 3'h0);
    apb(1'b0, OFS_PW_LO, 32'h0);
    chk(rv, PW_VAL[31:0]);
    apb(1'b0, OFS_PW_HI, 32'h0);
    chk(rv, PW_VAL[63:32]);
    op(OP_UNLOCK, 3'h0);
    chk({31'h0, i_dev.unlocked_r}, 32'h1);
    apb(1'b1, OFS_PW_HI, PW_VAL[63:32] ^ 32'h0100_0000);
    op(OP_UNLOCK, 3'h0);
    chk({31'h0, i_dev.unlocked_r}, 32'h0);
    op(OP_EXIT, 3'h0);
  endtask : t_password

  task t_protect;
    op(OP_ENTER, SEL_PERSIST);
    apb(1'b1, OFS_ADDR, {9'h0, 7'd5, 16'h1234});
    op(OP_PROT_SET, 3'h0);
    prot({7'd5, 16'hfedc}, 1'b1);
    prot({7'd6, 16'h1234}, 1'b0);
    op(OP_ERASE, 3'h0);
    prot({7'd5, 16'h0000}, 1'b0);
    op(OP_EXIT, 3'h0);
    op(OP_ENTER, SEL_FREEZE);
    prot(23'h0, 1'b0);
    op(OP_PROT_SET, 3'h0);
    prot(23'h7a_bcde, 1'b1);
    op(OP_RESET, 3'h0);
    op(OP_ENTER, SEL_DYNAMIC);
    apb(1'b1, OFS_ADDR, {9'h0, 7'd3, 16'h0040});
    op(OP_PROT_SET, 3'h0);
    prot({7'd3, 16'hffff}, 1'b1);
    op(OP_DYN_CLR, 3'h0);
    prot({7'd3, 16'h0001}, 1'b0);
    op(OP_ERASE, 3'h0);
    chk({31'h0, rv[STAT_ERR_BIT]}, 32'h1);
    op(OP_EXIT, 3'h0);
  endtask : t_protect

  //////////////////////////////////////////////////////////////////
  task end_sim;
    if (n_mismatch == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  initial
  begin
    rstn    = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    t_idle;
    t_sets;
    t_password;
    t_protect;
    end_sim;
  end

  // whole run needs under two thousand cycles
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    n_mismatch++;
    end_sim;
  end
endmodule : protect_cmd_host_bench

bind protect_cmd_host protect_cmd_host_checker i_chk (
  .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .flash(flash)
);
